// >>> mecr_top.sv
/*
 Extended control and status registers of a 10/100 MAC behind an
 index/data host port with active-low strobes. Assumes the transmit,
 receive and management engines run on clk_i; host pins are async.
*/
module mecr_top #(
  parameter logic [11:0] ETT_STEP = 12'h080,
  parameter logic [4:0] INT_PHY_ADDR = 5'h01
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Host pins
  input wire logic host_cmd_i,
  input wire logic host_write_strobe_n_i,
  input wire logic host_read_strobe_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  // Chip mode
  input wire logic mode16_i,
  // Transmit engine
  input wire logic tx_cmd_i,
  input wire logic tx_done_i,
  input wire logic tx_underrun_i,
  input wire logic [11:0] tx_fifo_count_i,
  input wire logic tx_frame_open_i,
  input wire logic [1:0] early_tx_slot_i,
  output logic tx_cmd_accept_o,
  output logic tx_cmd_refuse_o,
  output logic tx_retry_o,
  output logic [6:0] frame_gap_bits_o,
  output logic early_tx_start_o,
  output logic [2:0] sum_gen_en_o,
  output logic force_late_collision_o,
  output logic force_max_backoff_o,
  output logic force_min_backoff_o,
  // System and test
  input wire logic sram_oe_req_i,
  input wire logic sram_cs_req_i,
  output logic [1:0] sys_clock_select_o,
  output logic sram_oe_o,
  output logic sram_cs_o,
  output logic [2:0] phy_test_mode_o,
  // Receive engine
  input wire logic rx_done_i,
  input wire mecr_pkg::mecr_rx_class_t rx_class_i,
  output logic [7:0] rx_hdr_status_o,
  output logic rx_hdr_valid_o,
  output logic rx_drop_o,
  // Management engine
  input wire logic mdc_i,
  input wire logic mdio_out_i,
  input wire logic mdio_oe_i,
  output logic mdio_in_o,
  output logic [4:0] mgmt_phy_addr_o,
  // LED pins
  input wire logic [1:0] led_status_i,
  input wire logic [1:0] led_pin_i,
  output logic [1:0] led_pin_o,
  output logic [1:0] led_pin_oe_o
);
  import mecr_pkg::*;

  if (ETT_STEP == 12'h000) begin : g_chk
    $error("ETT_STEP must be nonzero");
  end

  localparam int SYNC_W = 13;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic cmd_s;
  logic wr_s;
  logic rd_s;
  logic [7:0] data_s;
  logic [1:0] led_s;
  logic [SPIKE_CYC:0] wr_hist_r;
  logic [SPIKE_CYC:0] rd_hist_r;
  logic wr_filt;
  logic rd_filt;
  logic wr_act_r;
  logic rd_act_r;
  logic wr_start;
  logic rd_start;
  logic [7:0] index_r;
  logic [7:0] rdata;
  logic reg_wr;

  logic [7:0] tx_ctrl2_r;
  logic [7:0] test_r;
  logic [7:0] special_r;
  logic early_tx_enable_r;
  logic [1:0] early_tx_threshold_r;
  logic [1:0] early_tx_status_r;
  logic [2:0] sum_gen_r;
  mecr_rx_class_t rx_class_r;
  logic rx_sum_check_en_r;
  logic drop_bad_sum_r;
  logic adr_en_r;
  logic [4:0] ext_phy_addr_value_r;
  logic led_gpio_mode_r;
  logic led_mgmt_mode_r;
  logic [7:0] bus_ctrl_r;
  logic [3:1] gp_dir_r;
  logic [3:1] gp_data_r;

  logic [1:0] tx_out_r;
  logic [1:0] tx_out_nxt;
  logic [1:0] tx_limit;
  logic tx_accept;
  logic [11:0] et_thr;
  logic et_fired_r;
  logic et_hit;
  logic rx_bad;

  // Pin synchroniser, stage one read only by stage two
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_r <= {SYNC_W{1'b1}};
      sync2_r <= {SYNC_W{1'b1}};
    end else begin
      sync1_r <= {led_pin_i, host_data_i, host_read_strobe_n_i,
                  host_write_strobe_n_i, host_cmd_i};
      sync2_r <= sync1_r;
    end
  end

  assign cmd_s = sync2_r[0];
  assign wr_s = ~sync2_r[1];
  assign rd_s = ~sync2_r[2];
  assign data_s = sync2_r[10:3];
  assign led_s = sync2_r[12:11];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_hist_r <= '0;
      rd_hist_r <= '0;
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end else begin
      wr_hist_r <= {wr_hist_r[SPIKE_CYC-1:0], wr_s};
      rd_hist_r <= {rd_hist_r[SPIKE_CYC-1:0], rd_s};
      wr_act_r <= wr_filt;
      rd_act_r <= rd_filt;
    end
  end

  assign wr_filt = bus_ctrl_r[BUS_WR_FILT_BIT] ? (&wr_hist_r) : wr_hist_r[0];
  assign rd_filt = bus_ctrl_r[BUS_RD_FILT_BIT] ? (&rd_hist_r) : rd_hist_r[0];
  assign wr_start = wr_filt & ~wr_act_r;
  assign rd_start = rd_filt & ~rd_act_r;
  assign reg_wr = wr_start & cmd_s;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      index_r <= RST_ZERO;
    end else if (wr_start && !cmd_s) begin
      index_r <= data_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_ctrl2_r <= RST_ZERO;
      test_r <= RST_ZERO;
      special_r <= RST_ZERO;
      early_tx_enable_r <= 1'b0;
      early_tx_threshold_r <= 2'h0;
      sum_gen_r <= 3'h0;
      rx_sum_check_en_r <= 1'b0;
      drop_bad_sum_r <= 1'b0;
      adr_en_r <= 1'b0;
      ext_phy_addr_value_r <= RST_EXT_PHY_ADDR;
      led_gpio_mode_r <= 1'b0;
      led_mgmt_mode_r <= 1'b0;
      bus_ctrl_r <= RST_BUS_CTRL;
      gp_dir_r <= 3'h0;
      gp_data_r <= 3'h0;
    end else if (reg_wr) begin
      case (index_r)
        OFS_TX_CTRL2: tx_ctrl2_r <= data_s;
        OFS_TEST: test_r <= data_s;
        OFS_SPECIAL: special_r <= data_s;
        OFS_EARLY_TX: begin
          early_tx_enable_r <= data_s[7];
          early_tx_threshold_r <= data_s[1:0];
        end
        OFS_SUM_GEN: sum_gen_r <= data_s[2:0];
        OFS_RX_SUM: begin
          rx_sum_check_en_r <= data_s[1];
          drop_bad_sum_r <= data_s[0];
        end
        OFS_PHY_ADDR: begin
          adr_en_r <= data_s[ADR_EN_BIT];
          ext_phy_addr_value_r <= data_s[4:0];
        end
        OFS_LED_FUNC: begin
          led_gpio_mode_r <= data_s[1];
          led_mgmt_mode_r <= data_s[0];
        end
        OFS_BUS_CTRL: bus_ctrl_r <= data_s;
        OFS_GP_CTRL: gp_dir_r <= data_s[3:1];
        OFS_GP_DATA: gp_data_r <= data_s[3:1];
        default: begin
        end
      endcase
    end
  end

  // Read mux; pin level shown for inputs among GP bits 2..1
  always_comb begin
    rdata = RST_ZERO;
    case (index_r)
      OFS_TX_CTRL2: rdata = tx_ctrl2_r;
      OFS_TEST: rdata = test_r;
      OFS_SPECIAL: rdata = special_r;
      OFS_EARLY_TX: rdata = {early_tx_enable_r, early_tx_status_r, 3'h0,
                             early_tx_threshold_r};
      OFS_SUM_GEN: rdata = {5'h00, sum_gen_r};
      OFS_RX_SUM: rdata = {rx_class_r, rx_sum_check_en_r, drop_bad_sum_r};
      OFS_PHY_ADDR: rdata = {adr_en_r, 2'h0, ext_phy_addr_value_r};
      OFS_LED_FUNC: rdata = {6'h00, led_gpio_mode_r, led_mgmt_mode_r};
      OFS_BUS_CTRL: rdata = bus_ctrl_r;
      OFS_GP_CTRL: rdata = {4'h7, gp_dir_r, 1'b1};
      OFS_GP_DATA: rdata = {4'h0, gp_data_r[3],
                            gp_dir_r[2] ? gp_data_r[2] : led_s[1],
                            gp_dir_r[1] ? gp_data_r[1] : led_s[0], 1'b0};
      default: rdata = RST_ZERO;
    endcase
    if (!cmd_s) begin
      rdata = index_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      host_data_o <= RST_ZERO;
      host_data_oe_o <= 1'b0;
    end else begin
      host_data_oe_o <= rd_filt;
      if (rd_start) begin
        host_data_o <= rdata;
      end
    end
  end

  assign tx_limit = tx_ctrl2_r[TX2_SINGLE_Q_BIT] ? 2'h1 : TX_MAX_OUTSTANDING;
  assign tx_accept = tx_cmd_i && (tx_out_r < tx_limit);

  always_comb begin
    tx_out_nxt = tx_out_r;
    if (tx_done_i && tx_out_r != 2'h0) begin
      tx_out_nxt = tx_out_nxt - 2'h1;
    end
    if (tx_accept) begin
      tx_out_nxt = tx_out_nxt + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_out_r <= 2'h0;
      tx_cmd_accept_o <= 1'b0;
      tx_cmd_refuse_o <= 1'b0;
      tx_retry_o <= 1'b0;
    end else begin
      tx_out_r <= tx_out_nxt;
      tx_cmd_accept_o <= tx_accept;
      tx_cmd_refuse_o <= tx_cmd_i & ~tx_accept;
      tx_retry_o <= tx_underrun_i & ~tx_ctrl2_r[TX2_RETRY_DIS_BIT];
    end
  end

  // threshold is (code + 1) steps
  assign et_thr = 12'(({10'h000, early_tx_threshold_r} + 12'h001) * ETT_STEP);
  assign et_hit = tx_frame_open_i && !et_fired_r && (tx_fifo_count_i >= et_thr);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      et_fired_r <= 1'b0;
      early_tx_start_o <= 1'b0;
      early_tx_status_r <= 2'h0;
    end else begin
      early_tx_start_o <= early_tx_enable_r & et_hit;
      if (!tx_frame_open_i) begin
        et_fired_r <= 1'b0;
      end else if (early_tx_enable_r && et_hit) begin
        et_fired_r <= 1'b1;
      end
      early_tx_status_r <= early_tx_slot_i;
    end
  end

  assign rx_bad = rx_class_i.ip_sum_fail | rx_class_i.tcp_sum_fail |
                  rx_class_i.udp_sum_fail;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_class_r <= '0;
      rx_hdr_status_o <= RST_ZERO;
      rx_hdr_valid_o <= 1'b0;
      rx_drop_o <= 1'b0;
    end else begin
      rx_hdr_valid_o <= rx_done_i;
      rx_drop_o <= rx_done_i & drop_bad_sum_r & rx_bad;
      if (rx_done_i) begin
        rx_class_r <= rx_class_i;
        rx_hdr_status_o <= rx_sum_check_en_r ? {rx_class_i, 2'h0} : RST_ZERO;
      end
    end
  end

  // Control outputs, all registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      frame_gap_bits_o <= IFG_DEFAULT_BITS;
      sum_gen_en_o <= 3'h0;
      force_late_collision_o <= 1'b0;
      force_max_backoff_o <= 1'b0;
      force_min_backoff_o <= 1'b0;
      sys_clock_select_o <= 2'h0;
      sram_oe_o <= 1'b0;
      sram_cs_o <= 1'b0;
      phy_test_mode_o <= 3'h0;
      mgmt_phy_addr_o <= INT_PHY_ADDR;
    end else begin
      // gap code to bit times; code 1101 lands on 104
      frame_gap_bits_o <= tx_ctrl2_r[3] ?
          7'(IFG_BASE_BITS + ({4'h0, tx_ctrl2_r[2:0]} << IFG_STEP_SHIFT)) :
          IFG_DEFAULT_BITS;
      sum_gen_en_o <= sum_gen_r;
      force_late_collision_o <= special_r[SPC_ENABLE_BIT] & special_r[SPC_LATE_COL_BIT];
      force_max_backoff_o <= special_r[SPC_ENABLE_BIT] & special_r[SPC_MAX_BO_BIT];
      force_min_backoff_o <= special_r[SPC_ENABLE_BIT] & special_r[SPC_MIN_BO_BIT];
      sys_clock_select_o <= test_r[7:6];
      sram_oe_o <= sram_oe_req_i | test_r[TST_SRAM_OE_BIT];
      sram_cs_o <= sram_cs_req_i | test_r[TST_SRAM_CS_BIT];
      phy_test_mode_o <= test_r[2:0];
      mgmt_phy_addr_o <= (adr_en_r && led_mgmt_mode_r) ? ext_phy_addr_value_r :
                         INT_PHY_ADDR;
    end
  end

  // Management mode wins if both LED modes are set
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      led_pin_o <= 2'h0;
      led_pin_oe_o <= 2'h0;
      mdio_in_o <= 1'b0;
    end else begin
      mdio_in_o <= led_s[0];
      if (mode16_i && led_mgmt_mode_r) begin
        led_pin_o <= {mdc_i, mdio_out_i};
        led_pin_oe_o <= {1'b1, mdio_oe_i};
      end else if (mode16_i && led_gpio_mode_r) begin
        led_pin_o <= gp_data_r[2:1];
        led_pin_oe_o <= gp_dir_r[2:1];
      end else begin
        led_pin_o <= led_status_i;
        led_pin_oe_o <= 2'h3;
      end
    end
  end

endmodule : mecr_top

// >>> mecr_pkg.sv
/*
 Constants, field layout and carrier types of the extended MAC
 control register group. Assumes one 200 MHz clock and an
 index/data host port driven by the host processor.
*/
package mecr_pkg;
  localparam logic [7:0] OFS_GP_CTRL = 8'h1e;
  localparam logic [7:0] OFS_GP_DATA = 8'h1f;
  localparam logic [7:0] OFS_TX_CTRL2 = 8'h2d;
  localparam logic [7:0] OFS_TEST = 8'h2e;
  localparam logic [7:0] OFS_SPECIAL = 8'h2f;
  localparam logic [7:0] OFS_EARLY_TX = 8'h30;
  localparam logic [7:0] OFS_SUM_GEN = 8'h31;
  localparam logic [7:0] OFS_RX_SUM = 8'h32;
  localparam logic [7:0] OFS_PHY_ADDR = 8'h33;
  localparam logic [7:0] OFS_LED_FUNC = 8'h34;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h38;
  // Field positions
  localparam int TX2_RETRY_DIS_BIT = 5;
  localparam int TX2_SINGLE_Q_BIT = 4;
  localparam int TST_SRAM_OE_BIT = 4;
  localparam int TST_SRAM_CS_BIT = 3;
  localparam int SPC_ENABLE_BIT = 7;
  localparam int SPC_LATE_COL_BIT = 2;
  localparam int SPC_MAX_BO_BIT = 1;
  localparam int SPC_MIN_BO_BIT = 0;
  localparam int ADR_EN_BIT = 7;
  localparam int BUS_WR_FILT_BIT = 1;
  localparam int BUS_RD_FILT_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BUS_CTRL = 8'h01;
  localparam logic [4:0] RST_EXT_PHY_ADDR = 5'h01;
  // Inter-frame gap in bit times
  localparam logic [6:0] IFG_DEFAULT_BITS = 7'h60;
  localparam logic [6:0] IFG_BASE_BITS = 7'h40;
  localparam int IFG_STEP_SHIFT = 3;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SPIKE_NS = 2;
  localparam int SPIKE_CYC_RAW = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
  localparam logic [1:0] TX_MAX_OUTSTANDING = 2'h2;
  // Receive classification, laid out as status bits 7..2
  typedef struct packed {
    logic udp_sum_fail;
    logic tcp_sum_fail;
    logic ip_sum_fail;
    logic udp_frame_flag;
    logic tcp_frame_flag;
    logic ip_frame_flag;
  } mecr_rx_class_t;
endpackage : mecr_pkg

// >>> mecr_top_assertions.sv
/*
 Port-level checks on the extended MAC control block.
 Assumes a bind onto mecr_top, one clock and a sync reset.
*/
module mecr_top_checker
  import mecr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Transmit
  input wire logic tx_cmd_i,
  input wire logic tx_underrun_i,
  input wire logic tx_frame_open_i,
  input wire logic tx_cmd_accept_o,
  input wire logic tx_cmd_refuse_o,
  input wire logic tx_retry_o,
  input wire logic [6:0] frame_gap_bits_o,
  input wire logic early_tx_start_o,
  // SRAM strobes
  input wire logic sram_oe_req_i,
  input wire logic sram_cs_req_i,
  input wire logic sram_oe_o,
  input wire logic sram_cs_o,
  // Receive
  input wire logic rx_done_i,
  input wire mecr_rx_class_t rx_class_i,
  input wire logic [7:0] rx_hdr_status_o,
  input wire logic rx_hdr_valid_o,
  input wire logic rx_drop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence cmd_answer_s;
    tx_cmd_accept_o ^ tx_cmd_refuse_o;
  endsequence
  sequence rx_answer_s;
    rx_hdr_valid_o ##0 (rx_hdr_status_o[1:0] == 2'h0);
  endsequence
  cmd_answer_a:
    assert property (tx_cmd_i |=> cmd_answer_s) else $error("tx command unanswered");
  cmd_cause_a:
    assert property ((tx_cmd_accept_o || tx_cmd_refuse_o) |-> $past(tx_cmd_i))
    else $error("tx answer without command");
  retry_cause_a:
    assert property (tx_retry_o |-> $past(tx_underrun_i)) else $error("retry without underrun");
  gap_range_a:
    assert property (frame_gap_bits_o == 7'h60 || (frame_gap_bits_o[2:0] == 3'h0 &&
      frame_gap_bits_o >= 7'h40 && frame_gap_bits_o <= 7'h78)) else $error("bad gap value");
  early_once_a:
    assert property (early_tx_start_o |-> $past(tx_frame_open_i) ##1 !early_tx_start_o)
    else $error("early start misplaced");
  sram_oe_a:
    assert property (sram_oe_req_i |=> sram_oe_o) else $error("sram oe lost");
  sram_cs_a:
    assert property (sram_cs_req_i |=> sram_cs_o) else $error("sram cs lost");
  rx_answer_a:
    assert property (rx_done_i |=> rx_answer_s) else $error("rx header missing");
  rx_status_a:
    assert property (rx_hdr_valid_o && rx_hdr_status_o != 8'h00 |->
      rx_hdr_status_o[7:2] == $past(rx_class_i)) else $error("rx header flags wrong");
  rx_drop_a:
    assert property (rx_drop_o |-> $past(rx_done_i) && $past(rx_class_i[5:3]) != 3'h0)
    else $error("drop without checksum fault");
endmodule : mecr_top_checker

// >>> mecr_host_model.sv
/*
 Host processor on the index/data port.
 Assumes active-low strobes sampled on clk_i by the device.
*/
module mecr_host_model (
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic cmd_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_data;
  initial begin
    cmd_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic xfer(input logic c, input logic w, input logic [7:0] d, input int len);
    @(posedge clk_i);
    cmd_o <= c;
    data_o <= d;
    if (w) wr_n_o <= 1'b0;
    else rd_n_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    rd_data = data_i;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Released bus must not look stable
    data_o <= ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, 1'b1, a, 8);
    xfer(1'b1, 1'b1, d, 8);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, 1'b1, a, 8);
    xfer(1'b1, 1'b0, 8'h00, 8);
  endtask : rd
endmodule : mecr_host_model

// >>> mecr_top_tb.sv
/*
 Self-checking bench for the extended MAC control block.
 Assumes the host model above and the package constants.
*/
module mecr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mecr_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic host_cmd_i, host_write_strobe_n_i, host_read_strobe_n_i, host_data_oe_o;
  logic [7:0] host_data_i, host_data_o, hd_w, rx_hdr_status_o;
  logic mode16_i = 1'b1, tx_cmd_i = 1'b0, tx_done_i = 1'b0, tx_underrun_i = 1'b0;
  logic tx_frame_open_i = 1'b0, sram_oe_req_i = 1'b0, sram_cs_req_i = 1'b0;
  logic rx_done_i = 1'b0, mdc_i = 1'b0, mdio_out_i = 1'b0, mdio_oe_i = 1'b0;
  logic [11:0] tx_fifo_count_i = 12'h000;
  logic [1:0] early_tx_slot_i = 2'h2, led_status_i = 2'h0, led_pin_i;
  mecr_rx_class_t rx_class_i = 6'h00;
  logic tx_cmd_accept_o, tx_cmd_refuse_o, tx_retry_o, early_tx_start_o, mdio_in_o;
  logic force_late_collision_o, force_max_backoff_o, force_min_backoff_o;
  logic sram_oe_o, sram_cs_o, rx_hdr_valid_o, rx_drop_o;
  logic [6:0] frame_gap_bits_o;
  logic [2:0] sum_gen_en_o, phy_test_mode_o;
  logic [1:0] sys_clock_select_o, led_pin_o, led_pin_oe_o;
  logic [4:0] mgmt_phy_addr_o;
  int num_errors = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  // Pins pulled up when nobody drives
  assign led_pin_i = (led_pin_oe_o & led_pin_o) | ~led_pin_oe_o;
  assign host_data_i = host_data_oe_o ? host_data_o : hd_w;
  mecr_host_model u_host (.clk_i, .cmd_o(host_cmd_i), .wr_n_o(host_write_strobe_n_i),
    .rd_n_o(host_read_strobe_n_i), .data_o(hd_w), .data_i(host_data_i));
  mecr_top uut (.clk_i, .srst_i, .host_cmd_i, .host_write_strobe_n_i, .host_read_strobe_n_i,
    .host_data_i, .host_data_o, .host_data_oe_o, .mode16_i, .tx_cmd_i, .tx_done_i,
    .tx_underrun_i, .tx_fifo_count_i, .tx_frame_open_i, .early_tx_slot_i, .tx_cmd_accept_o,
    .tx_cmd_refuse_o, .tx_retry_o, .frame_gap_bits_o, .early_tx_start_o, .sum_gen_en_o,
    .force_late_collision_o, .force_max_backoff_o, .force_min_backoff_o, .sram_oe_req_i,
    .sram_cs_req_i, .sys_clock_select_o, .sram_oe_o, .sram_cs_o, .phy_test_mode_o,
    .rx_done_i, .rx_class_i, .rx_hdr_status_o, .rx_hdr_valid_o, .rx_drop_o, .mdc_i,
    .mdio_out_i, .mdio_oe_i, .mdio_in_o, .mgmt_phy_addr_o, .led_status_i, .led_pin_i,
    .led_pin_o, .led_pin_oe_o);
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a);
    chk(n, {4'h0, e}, {4'h0, u_host.rd_data});
  endtask : rdc
  task automatic cmd(input logic e);
    @(posedge clk_i);
    tx_cmd_i <= 1'b1;
    @(posedge clk_i);
    tx_cmd_i <= 1'b0;
    #1 chk("accept", {11'h0, e}, {11'h0, tx_cmd_accept_o});
    chk("refuse", {11'h0, !e}, {11'h0, tx_cmd_refuse_o});
  endtask : cmd
  task automatic done;
    @(posedge clk_i);
    tx_done_i <= 1'b1;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
  endtask : done
  task automatic retry(input logic e);
    @(posedge clk_i);
    tx_underrun_i <= 1'b1;
    @(posedge clk_i);
    tx_underrun_i <= 1'b0;
    #1 chk("retry", {11'h0, e}, {11'h0, tx_retry_o});
  endtask : retry
  task automatic rx(input logic [5:0] c, input logic [7:0] s, input logic d);
    @(posedge clk_i);
    rx_class_i <= c;
    rx_done_i <= 1'b1;
    @(posedge clk_i);
    rx_done_i <= 1'b0;
    #1 chk("rx status", {4'h0, s}, {4'h0, rx_hdr_status_o});
    chk("rx drop", {11'h0, d}, {11'h0, rx_drop_o});
  endtask : rx
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    rdc("bus ctrl", OFS_BUS_CTRL, 8'h01);
    rdc("phy addr", OFS_PHY_ADDR, 8'h01);
    chk("gap", 12'h060, {5'h0, frame_gap_bits_o});
    $display("test reset done");
    for (int g = 0; g < 16; g++) begin
      u_host.wr(OFS_TX_CTRL2, 8'(g));
      chk("gap", 12'(g < 8 ? 96 : 64 + 8 * (g - 8)), {5'h0, frame_gap_bits_o});
    end
    $display("test gap done");
    for (int c = 0; c < 3; c++) begin
      u_host.wr(OFS_TEST, {2'(c), 6'h1d});
      chk("clk sel", 12'(c), {10'h0, sys_clock_select_o});
      chk("force sram", {9'h0, 3'h7}, {9'h0, phy_test_mode_o[2], sram_oe_o, sram_cs_o});
      rdc("test reg", OFS_TEST, {2'(c), 6'h1d});
    end
    u_host.wr(OFS_TEST, 8'h00);
    chk("sram off", 12'h000, {10'h0, sram_oe_o, sram_cs_o});
    sram_oe_req_i <= 1'b1;
    sram_cs_req_i <= 1'b1;
    $display("test sys done");
    u_host.wr(OFS_SPECIAL, 8'h07);
    chk("forces", 12'h000, {9'h0, force_late_collision_o, force_max_backoff_o,
      force_min_backoff_o});
    u_host.wr(OFS_SPECIAL, 8'h87);
    chk("forces", 12'h007, {9'h0, force_late_collision_o, force_max_backoff_o,
      force_min_backoff_o});
    u_host.wr(OFS_SUM_GEN, 8'h07);
    chk("sum gen", 12'h007, {9'h0, sum_gen_en_o});
    rdc("sum gen", OFS_SUM_GEN, 8'h07);
    $display("test modes done");
    u_host.wr(OFS_EARLY_TX, 8'h81);
    rdc("early stat", OFS_EARLY_TX, 8'hc1);
    tx_fifo_count_i <= 12'h0ff;
    tx_frame_open_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("early", 12'h000, {11'h0, early_tx_start_o});
    @(posedge clk_i);
    tx_fifo_count_i <= 12'h100;
    @(posedge clk_i);
    #1 chk("early", 12'h001, {11'h0, early_tx_start_o});
    $display("test early done");
    u_host.wr(OFS_TX_CTRL2, 8'h30);
    retry(1'b0);
    cmd(1'b1);
    cmd(1'b0);
    done();
    cmd(1'b1);
    done();
    u_host.wr(OFS_TX_CTRL2, 8'h00);
    retry(1'b1);
    cmd(1'b1);
    cmd(1'b1);
    cmd(1'b0);
    $display("test queue done");
    u_host.wr(OFS_RX_SUM, 8'h03);
    rx(6'h09, 8'h24, 1'b1);
    rdc("rx sum", OFS_RX_SUM, 8'h27);
    u_host.wr(OFS_RX_SUM, 8'h02);
    rx(6'h12, 8'h48, 1'b0);
    u_host.wr(OFS_RX_SUM, 8'h00);
    rx(6'h12, 8'h00, 1'b0);
    $display("test rx done");
    u_host.wr(OFS_LED_FUNC, 8'h01);
    u_host.wr(OFS_PHY_ADDR, 8'h95);
    chk("mgmt addr", 12'h015, {7'h0, mgmt_phy_addr_o});
    mdc_i <= 1'b1;
    mdio_oe_i <= 1'b1;
    // Pin, two sync stages and output register before mdio_in_o moves
    repeat (5) @(posedge clk_i);
    #1 chk("mgmt pins", 12'h00e, {8'h0, led_pin_oe_o[1], led_pin_o[1], led_pin_oe_o[0],
      mdio_in_o});
    $display("test mgmt done");
    u_host.wr(OFS_GP_CTRL, 8'h05);
    u_host.wr(OFS_GP_DATA, 8'h04);
    u_host.wr(OFS_LED_FUNC, 8'h02);
    chk("gp pins", 12'h00a, {8'h0, led_pin_oe_o, led_pin_o});
    chk("int addr", 12'h001, {7'h0, mgmt_phy_addr_o});
    rdc("gp data", OFS_GP_DATA, 8'h06);
    mode16_i <= 1'b0;
    led_status_i <= 2'h1;
    repeat (2) @(posedge clk_i);
    #1 chk("led normal", 12'h00d, {8'h0, led_pin_oe_o, led_pin_o});
    $display("test gpio done");
    u_host.xfer(1'b0, 1'b1, OFS_SUM_GEN, 8);
    u_host.xfer(1'b1, 1'b1, 8'h05, 1);
    rdc("short wr", OFS_SUM_GEN, 8'h05);
    u_host.wr(OFS_BUS_CTRL, 8'h03);
    u_host.xfer(1'b0, 1'b1, OFS_SUM_GEN, 8);
    u_host.xfer(1'b1, 1'b1, 8'h00, 1);
    rdc("spike wr", OFS_SUM_GEN, 8'h05);
    $display("test spike done");
    summarize();
  end
endmodule : mecr_top_tb
bind mecr_top mecr_top_checker u_chk (.clk_i, .srst_i, .tx_cmd_i, .tx_underrun_i,
  .tx_frame_open_i, .tx_cmd_accept_o, .tx_cmd_refuse_o, .tx_retry_o, .frame_gap_bits_o,
  .early_tx_start_o, .sram_oe_req_i, .sram_cs_req_i, .sram_oe_o, .sram_cs_o, .rx_done_i,
  .rx_class_i, .rx_hdr_status_o, .rx_hdr_valid_o, .rx_drop_o);
